/* hw/spx_serial_port.sv */
// Serial port: synchronous shift mode and asynchronous 10/11-bit modes.
// Assumes timer overflow pulses on clk_in; serial pins come from outside.
`timescale 1ns/10ps
`include "spx_cfg.svh"
module spx_serial_port import spx_pkg::*; #(
    parameter int ADDR_W = 4
) (
    // Clock and reset
    input wire logic clk_in,
    input wire logic resetn_in,
    // Avalon-MM slave
    input wire logic [ADDR_W-1:0] avs_address_in,
    input wire logic avs_read_in,
    input wire logic avs_write_in,
    input wire logic [31:0] avs_writedata_in,
    input wire logic [3:0] avs_byteenable_in,
    output logic [31:0] avs_readdata_out,
    output logic avs_waitrequest_out,
    // Baud sources
    input wire logic t1_ovf_in,
    input wire logic t2_ovf_in,
    // Serial pins
    input wire logic rxd_in,
    output logic rxd_out,
    output logic rxd_oe_out,
    output logic txd_out,
    output logic txd_oe_out
);
    if (ADDR_W < 4) begin : g_bad_addr
        $error("ADDR_W too small for the register map");
    end

    // Address match against a register offset
    function automatic logic spx_hit(input logic [ADDR_W-1:0] a, input logic [3:0] off);
        return a == ADDR_W'(off);
    endfunction

    // Bit order reversal of a left-shifted, LSB-first byte
    function automatic logic [7:0] spx_rev(input logic [7:0] v);
        logic [7:0] r;
        r = 8'h00;
        for (int i = 0; i < 8; i++) begin
            r[i] = v[7-i];
        end
        return r;
    endfunction

    logic [1:0] rst_sync_ff;
    logic rst_n;
    logic rxd_s1_ff, rxd_s2_ff, rxd_s3_ff;
    logic wait_ff;
    logic [31:0] rdata_ff;
    spx_ctrl_t ctrl_ff, nxt_ctrl;
    spx_baud_t baud_ff;
    logic [7:0] rx_buf_ff, nxt_rx_buf;
    spx_tx_st_t tx_st_ff, nxt_tx_st;
    spx_rx_st_t rx_st_ff, nxt_rx_st;
    logic [10:0] tx_sh_ff, nxt_tx_sh;
    logic [3:0] tx_left_ff, nxt_tx_left;
    logic [3:0] tx_cnt_ff, rx_cnt_ff, nxt_rx_cnt;
    logic [3:0] sc_cnt_ff, nxt_sc_cnt;
    logic [3:0] bits_ff, nxt_bits;
    logic [7:0] rx_sh_ff, nxt_rx_sh;
    logic ninth_ff, nxt_ninth;
    logic smp_a_ff, smp_b_ff;
    logic [1:0] fix_cnt_ff;
    logic t1_half_ff;
    logic txd_ff, txd_oe_ff, rxd_ff, rxd_oe_ff;
    logic set_ti, set_ri;

    // Reset release through two flip-flops
    always_ff @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            rst_sync_ff <= 2'b00;
        end else begin
            rst_sync_ff <= {rst_sync_ff[0], 1'b1};
        end
    end
    assign rst_n = rst_sync_ff[1];

    // Receive pin synchroniser plus one stage for edge finding
    always_ff @(posedge clk_in or negedge rst_n) begin
        if (!rst_n) begin
            rxd_s1_ff <= 1'b1;
            rxd_s2_ff <= 1'b1;
            rxd_s3_ff <= 1'b1;
        end else begin
            rxd_s1_ff <= rxd_in;
            rxd_s2_ff <= rxd_s1_ff;
            rxd_s3_ff <= rxd_s2_ff;
        end
    end

    // Bus decode: one wait cycle, access completes when wait is low
    wire bus_req = avs_read_in | avs_write_in;
    wire bus_acc = bus_req & ~wait_ff;
    wire bus_wr = bus_acc & avs_write_in & avs_byteenable_in[0];
    wire wr_buf = bus_wr & spx_hit(avs_address_in, `SPX_ADDR_BUF);
    wire wr_ctl = bus_wr & spx_hit(avs_address_in, `SPX_ADDR_CTL);
    wire wr_baud = bus_wr & spx_hit(avs_address_in, `SPX_ADDR_BAUD);
    wire [7:0] rd_sel = spx_hit(avs_address_in, `SPX_ADDR_BUF) ? rx_buf_ff :
                        spx_hit(avs_address_in, `SPX_ADDR_CTL) ? ctrl_ff :
                        spx_hit(avs_address_in, `SPX_ADDR_BAUD) ? {5'h00, baud_ff} : 8'h00;

    // Bus handshake and read data
    always_ff @(posedge clk_in or negedge rst_n) begin
        if (!rst_n) begin
            wait_ff <= 1'b1;
            rdata_ff <= 32'h0000_0000;
        end else begin
            wait_ff <= ~(bus_req & wait_ff);
            rdata_ff <= (bus_req & wait_ff) ? {24'h00_0000, rd_sel} : rdata_ff;
        end
    end
    assign avs_waitrequest_out = wait_ff;
    assign avs_readdata_out = rdata_ff;

    // Mode decode
    wire [1:0] mode = {ctrl_ff.mode_select_high, ctrl_ff.mode_select_low};
    wire sync_mode = (mode == 2'b00);
    wire long_frame = ctrl_ff.mode_select_high;
    wire [3:0] last_idx = long_frame ? `SPX_LAST_11 : `SPX_LAST_10;
    wire [3:0] sc_div = ctrl_ff.multiproc_or_rate_select ? `SPX_DIV_FAST : `SPX_DIV_SLOW;
    wire [3:0] sc_half = {1'b0, sc_div[3:1]};

    // 16x ticks: fixed clock division, timer1 halved unless doubled, or timer2
    wire fix_tick = baud_ff.baud_double ? fix_cnt_ff[0] : (fix_cnt_ff == `SPX_FIX_SLOW);
    wire t1_tick = t1_ovf_in & (baud_ff.baud_double | t1_half_ff);
    wire tx_tick = (mode == 2'b10) ? fix_tick :
                   baud_ff.tx_timer2_source_select ? t2_ovf_in : t1_tick;
    wire rx_tick = (mode == 2'b10) ? fix_tick :
                   baud_ff.rx_timer2_source_select ? t2_ovf_in : t1_tick;
    wire tx_roll = tx_tick & (tx_cnt_ff == `SPX_OVS_LAST);

    // Shift clock phase for the synchronous mode
    wire sc_fall = (sc_cnt_ff == 4'h0);
    wire sc_rise = (sc_cnt_ff == sc_half);
    wire sc_end = (sc_cnt_ff == sc_div - 4'h1);
    wire sc_level = (sc_cnt_ff >= sc_half);

    // Receive edge, samples and majority vote
    wire rx_fall = rxd_s3_ff & ~rxd_s2_ff;
    wire rx_mid = rx_tick & (rx_cnt_ff == `SPX_SMP_C);
    wire vote = (smp_a_ff & smp_b_ff) | (smp_a_ff & rxd_s2_ff) | (smp_b_ff & rxd_s2_ff);
    wire rb_val = long_frame ? ninth_ff : vote;
    wire rx_ok = ~ctrl_ff.receive_done_flag & (~ctrl_ff.multiproc_or_rate_select | rb_val);

    // Transmit sequencer
    always_comb begin
        nxt_tx_st = tx_st_ff;
        nxt_tx_sh = tx_sh_ff;
        nxt_tx_left = tx_left_ff;
        set_ti = 1'b0;
        case (tx_st_ff)
            TX_IDLE: begin
            end
            TX_WAIT: begin
                if (tx_roll) begin
                    nxt_tx_st = TX_SEND;
                end
            end
            TX_SEND: begin
                if (tx_roll) begin
                    if (tx_left_ff == 4'h0) begin
                        nxt_tx_st = TX_IDLE;
                    end else begin
                        nxt_tx_sh = {1'b1, tx_sh_ff[10:1]};
                        nxt_tx_left = tx_left_ff - 4'h1;
                        set_ti = (tx_left_ff == 4'h1);
                    end
                end
            end
            TX_SYNC: begin
                if (sc_fall && bits_ff != 4'h0) begin
                    nxt_tx_sh = {1'b0, tx_sh_ff[10:1]};
                end
                if (sc_end && bits_ff == `SPX_SYNC_BITS) begin
                    nxt_tx_st = TX_IDLE;
                    set_ti = 1'b1;
                end
            end
            default: begin
                nxt_tx_st = TX_IDLE;
            end
        endcase
        if (wr_buf) begin
            nxt_tx_st = sync_mode ? TX_SYNC : TX_WAIT;
            nxt_tx_sh = {1'b1, ctrl_ff.transmit_ninth_bit | ~long_frame, avs_writedata_in[7:0], 1'b0};
            nxt_tx_left = last_idx;
            if (sync_mode) begin
                nxt_tx_sh = {3'h7, avs_writedata_in[7:0]};
            end
        end
    end

    // Receive sequencer
    always_comb begin
        nxt_rx_st = rx_st_ff;
        nxt_rx_sh = rx_sh_ff;
        nxt_rx_cnt = rx_tick ? rx_cnt_ff + 4'h1 : rx_cnt_ff;
        nxt_rx_buf = rx_buf_ff;
        nxt_ninth = ninth_ff;
        set_ri = 1'b0;
        case (rx_st_ff)
            RX_IDLE: begin
                if (!sync_mode && ctrl_ff.receive_enable && rx_fall) begin
                    nxt_rx_st = RX_ASYNC;
                    nxt_rx_cnt = 4'h0;
                end else if (sync_mode && ctrl_ff.receive_enable && !ctrl_ff.receive_done_flag
                             && tx_st_ff == TX_IDLE && !wr_buf) begin
                    nxt_rx_st = RX_SYNC;
                end
            end
            RX_ASYNC: begin
                if (rx_mid) begin
                    if (bits_ff == 4'h0 && vote) begin
                        nxt_rx_st = RX_IDLE;
                    end else if (bits_ff == last_idx) begin
                        nxt_rx_st = RX_IDLE;
                        if (rx_ok) begin
                            nxt_rx_buf = spx_rev(rx_sh_ff);
                            set_ri = 1'b1;
                        end
                    end else if (bits_ff == `SPX_LAST_10) begin
                        nxt_ninth = vote;
                    end else if (bits_ff != 4'h0) begin
                        nxt_rx_sh = {rx_sh_ff[6:0], vote};
                    end
                end
            end
            RX_SYNC: begin
                if (sc_rise) begin
                    nxt_rx_sh = {rx_sh_ff[6:0], rxd_s2_ff};
                end
                if (sc_end && bits_ff == `SPX_SYNC_BITS) begin
                    nxt_rx_st = RX_IDLE;
                    nxt_rx_buf = spx_rev(rx_sh_ff);
                    set_ri = 1'b1;
                end
            end
            default: begin
                nxt_rx_st = RX_IDLE;
            end
        endcase
    end

    // Shared bit count and shift clock counter
    wire sync_busy = (tx_st_ff == TX_SYNC) | (rx_st_ff == RX_SYNC);
    assign nxt_sc_cnt = (!sync_busy || sc_end) ? 4'h0 : sc_cnt_ff + 4'h1;
    assign nxt_bits = (nxt_tx_st == TX_SYNC && wr_buf) ? 4'h0 :
                      (sync_busy && sc_rise) ? bits_ff + 4'h1 :
                      (rx_st_ff == RX_ASYNC && rx_mid) ? bits_ff + 4'h1 :
                      (sync_busy || rx_st_ff == RX_ASYNC) ? bits_ff : 4'h0;

    // Control register: hardware set wins over a software write
    always_comb begin
        nxt_ctrl = ctrl_ff;
        if (wr_ctl) begin
            nxt_ctrl = spx_ctrl_t'(avs_writedata_in[7:0]);
        end
        if (set_ti) begin
            nxt_ctrl.transmit_done_flag = 1'b1;
        end
        if (set_ri) begin
            nxt_ctrl.receive_done_flag = 1'b1;
            nxt_ctrl.received_ninth_bit = (rx_st_ff == RX_ASYNC) ? rb_val : ctrl_ff.received_ninth_bit;
        end
    end

    // Registers and sequencer state
    always_ff @(posedge clk_in or negedge rst_n) begin
        if (!rst_n) begin
            ctrl_ff <= spx_ctrl_t'(`SPX_CTL_RST);
            baud_ff <= spx_baud_t'(`SPX_BAUD_RST);
            rx_buf_ff <= 8'h00;
            tx_st_ff <= TX_IDLE;
            rx_st_ff <= RX_IDLE;
            tx_sh_ff <= 11'h7ff;
            tx_left_ff <= 4'h0;
            rx_sh_ff <= 8'h00;
            ninth_ff <= 1'b0;
            bits_ff <= 4'h0;
            sc_cnt_ff <= 4'h0;
            rx_cnt_ff <= 4'h0;
        end else begin
            ctrl_ff <= nxt_ctrl;
            baud_ff <= wr_baud ? spx_baud_t'(avs_writedata_in[2:0]) : baud_ff;
            rx_buf_ff <= nxt_rx_buf;
            tx_st_ff <= nxt_tx_st;
            rx_st_ff <= nxt_rx_st;
            tx_sh_ff <= nxt_tx_sh;
            tx_left_ff <= nxt_tx_left;
            rx_sh_ff <= nxt_rx_sh;
            ninth_ff <= nxt_ninth;
            bits_ff <= nxt_bits;
            sc_cnt_ff <= nxt_sc_cnt;
            rx_cnt_ff <= nxt_rx_cnt;
        end
    end

    // Baud dividers and sample capture
    always_ff @(posedge clk_in or negedge rst_n) begin
        if (!rst_n) begin
            tx_cnt_ff <= 4'h0;
            fix_cnt_ff <= 2'h0;
            t1_half_ff <= 1'b0;
            smp_a_ff <= 1'b1;
            smp_b_ff <= 1'b1;
        end else begin
            tx_cnt_ff <= tx_tick ? tx_cnt_ff + 4'h1 : tx_cnt_ff;
            fix_cnt_ff <= fix_cnt_ff + 2'h1;
            t1_half_ff <= t1_ovf_in ? ~t1_half_ff : t1_half_ff;
            smp_a_ff <= (rx_tick && rx_cnt_ff == `SPX_SMP_A) ? rxd_s2_ff : smp_a_ff;
            smp_b_ff <= (rx_tick && rx_cnt_ff == `SPX_SMP_B) ? rxd_s2_ff : smp_b_ff;
        end
    end

    // Pin drivers: transmit pin owned only while a frame or shift clock runs
    always_ff @(posedge clk_in or negedge rst_n) begin
        if (!rst_n) begin
            txd_ff <= 1'b1;
            txd_oe_ff <= 1'b0;
            rxd_ff <= 1'b1;
            rxd_oe_ff <= 1'b0;
        end else begin
            txd_ff <= sync_busy ? sc_level : (tx_st_ff == TX_SEND ? tx_sh_ff[0] : 1'b1);
            txd_oe_ff <= sync_busy | (tx_st_ff == TX_SEND);
            rxd_ff <= (tx_st_ff == TX_SYNC) ? tx_sh_ff[0] : 1'b1;
            rxd_oe_ff <= (tx_st_ff == TX_SYNC);
        end
    end
    assign txd_out = txd_ff;
    assign txd_oe_out = txd_oe_ff;
    assign rxd_out = rxd_ff;
    assign rxd_oe_out = rxd_oe_ff;

    default clocking @(posedge clk_in);
    endclocking
    default disable iff (!rst_n);

    chk_ti_sticky: assert property ($past(ctrl_ff.transmit_done_flag) && !$past(wr_ctl)
        |-> ctrl_ff.transmit_done_flag) else $error("transmit done dropped by hardware");
    chk_ri_sticky: assert property ($past(ctrl_ff.receive_done_flag) && !$past(wr_ctl)
        |-> ctrl_ff.receive_done_flag) else $error("receive done dropped by hardware");
    chk_txd_release: assert property (tx_st_ff == TX_IDLE && !sync_busy |=> !txd_oe_out)
        else $error("transmit pin held while idle");
    chk_sync_norestart: assert property (sync_mode && ctrl_ff.receive_done_flag && rx_st_ff == RX_IDLE
        && !wr_ctl |=> rx_st_ff == RX_IDLE) else $error("sync receive restarted");
    chk_start_abort: assert property (rx_st_ff == RX_ASYNC && rx_mid && bits_ff == 4'h0 && vote
        |=> rx_st_ff == RX_IDLE && !$rose(ctrl_ff.receive_done_flag) ##0 $stable(rx_buf_ff))
        else $error("bad start bit not aborted");
    chk_edge_reset: assert property (rx_st_ff == RX_IDLE && !sync_mode && ctrl_ff.receive_enable
        && rx_fall |=> rx_cnt_ff == 4'h0 && rx_st_ff == RX_ASYNC) else $error("edge did not reset counter");
    chk_ti_on_stop: assert property (tx_st_ff == TX_SEND && tx_roll && tx_left_ff == 4'h1
        |=> ctrl_ff.transmit_done_flag ##1 txd_out) else $error("stop bit without transmit done");
    chk_tx_align: assert property (tx_st_ff == TX_WAIT && !tx_roll && !wr_buf |=> tx_st_ff == TX_WAIT)
        else $error("transmit started off a rollover");
    chk_sclk_rate: assert property (sync_busy |-> sc_cnt_ff < sc_div)
        else $error("shift clock period too long");
    chk_read_buffer: assert property (bus_acc && avs_read_in && spx_hit(avs_address_in, `SPX_ADDR_BUF)
        |-> avs_readdata_out == {24'h00_0000, $past(rx_buf_ff)}) else $error("buffer read wrong");
endmodule

/* hw/spx_cfg.svh */
// Constants of the serial port: register offsets, reset values, timing counts.
// Assumes byte addressing on a 32-bit Avalon-MM bus, one register per word.
//
// Notes on behaviour
// - Buffer writes load transmit register; buffer reads return separate receive buffer.
// - Two mode bits pick synchronous 8-bit or asynchronous 10/11-bit framing.
// - Any buffer write starts a transmission in every mode.
// - Synchronous receive starts when enabled and receive-done is clear.
// - Asynchronous receive starts only on a start bit while enabled.
// - Synchronous mode: data on receive pin, clock on transmit pin, LSB first.
// - Synchronous shift clock is clock/12, or clock/4 when rate bit set.
// - Synchronous transmit starts next cycle, shifts right on falling clock edges.
// - After eighth bit, transmit-done set next cycle; data line left high.
// - Synchronous receive starts next cycle, samples on rising clock edges.
// - After eighth bit receive-done set; no restart until software clears it.
// - 10-bit frame: start 0, eight data LSB first, stop 1 into ninth-bit flag.
// - 10-bit rate is timer1 overflow /16 or /32, or timer2 overflow /16.
// - Asynchronous transmit starts after next divide-by-16 rollover following the write.
// - Start, data, stop sent; transmit-done set as stop bit goes out.
// - Receive pin sampled at 16x rate; counter reset on falling edge.
// - Each bit sampled at counter states 7, 8, 9; majority wins.
// - Start bit not zero aborts reception and rearms edge search.
// - Frame loaded only if receive-done clear and rate bit clear or stop set.
// - After middle of stop bit receiver searches for next falling edge.
// - Transmit pin driven only while transmitting or clocking a synchronous receive, released afterwards.
// - Timer2 chosen per direction by its select bits, otherwise timer1.
`ifndef SPX_CFG_SVH
`define SPX_CFG_SVH
`define SPX_ADDR_BUF 4'h0
`define SPX_ADDR_CTL 4'h4
`define SPX_ADDR_BAUD 4'h8
`define SPX_CTL_RST 8'h00
`define SPX_BAUD_RST 3'h0
`define SPX_DIV_SLOW 4'hc
`define SPX_DIV_FAST 4'h4
`define SPX_OVS_LAST 4'hf
`define SPX_SMP_A 4'h7
`define SPX_SMP_B 4'h8
`define SPX_SMP_C 4'h9
`define SPX_FIX_SLOW 2'h3
`define SPX_SYNC_BITS 4'h8
`define SPX_LAST_10 4'h9
`define SPX_LAST_11 4'ha
`endif

/* hw/spx_pkg.sv */
// Types of the serial port: control fields and state encodings.
// Assumes spx_cfg.svh supplies the numeric constants.
package spx_pkg;
    typedef struct packed {
        logic mode_select_high;
        logic mode_select_low;
        logic multiproc_or_rate_select;
        logic receive_enable;
        logic transmit_ninth_bit;
        logic received_ninth_bit;
        logic transmit_done_flag;
        logic receive_done_flag;
    } spx_ctrl_t;
    typedef struct packed {
        logic rx_timer2_source_select;
        logic tx_timer2_source_select;
        logic baud_double;
    } spx_baud_t;
    typedef enum logic [1:0] {TX_IDLE = 2'b00, TX_WAIT = 2'b01, TX_SEND = 2'b11, TX_SYNC = 2'b10} spx_tx_st_t;
    typedef enum logic [1:0] {RX_IDLE = 2'b00, RX_ASYNC = 2'b01, RX_SYNC = 2'b11, RX_SPARE = 2'b10} spx_rx_st_t;
endpackage

/* tb/spx_partner.sv */
// Far-side serial device: async frame sender and taker, sync-mode shift register.
// Assumes the bench resolves pin levels (pull-ups on both lines) and calls tasks from one thread.
`timescale 1ns/10ps
module spx_partner (
    // Clock
    input wire logic clk_in,
    // Resolved pin levels
    input wire logic txd_in,
    input wire logic rxd_in,
    // Receive line drive
    output logic rxd_out,
    output logic rxd_oe_out
);
    logic [7:0] sync_tx = 8'h00;
    logic [7:0] sync_rx = 8'h00;
    logic [2:0] sync_idx = 3'h0;
    logic sync_on = 1'b0;
    logic txd_q = 1'b1;
    int cyc = 0;
    int last_rise = 0;
    int rise_gap = 0;
    initial begin
        rxd_out = 1'b1;
        rxd_oe_out = 1'b0;
    end
    // Shift register: next bit out on a falling shift clock, capture and period on a rising one
    always @(posedge clk_in) begin
        cyc <= cyc + 1;
        txd_q <= txd_in;
        if (txd_q && !txd_in && sync_on) begin
            rxd_out <= sync_tx[sync_idx];
            sync_idx <= sync_idx + 3'h1;
        end
        if (!txd_q && txd_in) begin
            sync_rx <= {rxd_in, sync_rx[7:1]};
            rise_gap <= cyc - last_rise;
            last_rise <= cyc;
        end
    end
    // Loads the byte for a sync receive; off releases the line again
    task automatic sync_begin(input logic [7:0] b, input logic on);
        @(posedge clk_in);
        sync_tx <= b;
        sync_idx <= 3'h0;
        sync_on <= on;
        rxd_oe_out <= on;
    endtask
    // One async frame, LSB first; bit number glitch carries a pulse narrower than one tick
    task automatic send(input logic [9:0] frame, input int bitclk, input int glitch);
        for (int i = 0; i < 10; i++) begin
            for (int c = 0; c < bitclk; c++) begin
                @(posedge clk_in);
                rxd_oe_out <= 1'b1;
                rxd_out <= frame[i] ^ (i == glitch && c >= bitclk / 2 - 2 && c < bitclk / 2 + 2);
            end
        end
        @(posedge clk_in);
        rxd_oe_out <= 1'b0;
    endtask
    // Short low pulse that looks like a start edge, then idle long enough to rearm
    task automatic blip();
        @(posedge clk_in);
        rxd_oe_out <= 1'b1;
        rxd_out <= 1'b0;
        repeat (3) @(posedge clk_in);
        rxd_oe_out <= 1'b0;
        repeat (200) @(posedge clk_in);
    endtask
    // Takes one frame from the transmit line, sampling mid-bit; lag counts cycles to the start edge
    task automatic take(input int bitclk, output logic [9:0] frame, output int lag);
        for (lag = 0; lag < 4000 && txd_in !== 1'b0; lag++) @(posedge clk_in);
        repeat (bitclk / 2) @(posedge clk_in);
        for (int i = 0; i < 10; i++) begin
            frame[i] = txd_in;
            if (i < 9) repeat (bitclk) @(posedge clk_in);
        end
    endtask
endmodule

/* tb/spx_serial_port_test.sv */
// Self-checking bench of the serial port: bus tasks, timer tick source, one task per scenario.
// Assumes spx_partner on the far side; both serial lines have pull-ups.
`timescale 1ns/10ps
`include "spx_cfg.svh"
module spx_serial_port_test import spx_pkg::*;;
    logic clk_in = 1'b0;
    logic resetn_in = 1'b0;
    logic [3:0] adr = 4'h0;
    logic rd = 1'b0;
    logic wr = 1'b0;
    logic [31:0] wdat = 32'h0000_0000;
    logic [31:0] rdat;
    logic wreq;
    logic t1_ovf = 1'b0;
    logic t2_ovf = 1'b0;
    logic [2:0] tick_cnt = 3'h0;
    logic rxd_d, rxd_oe, txd_d, txd_oe, p_rxd, p_oe;
    logic [7:0] q;
    spx_ctrl_t ctl;
    int failures = 0;
    int check_count = 0;
    // Pin levels from all drivers, pull-up when nobody drives
    wire rxd_w = rxd_oe ? rxd_d : (p_oe ? p_rxd : 1'b1);
    wire txd_w = txd_oe ? txd_d : 1'b1;
    // Clock and timer overflow pulses: timer 1 every 8 cycles, timer 2 every 4
    always #4 clk_in = ~clk_in;
    always @(posedge clk_in) begin
        tick_cnt <= tick_cnt + 3'h1;
        t1_ovf <= (tick_cnt == 3'h7);
        t2_ovf <= (tick_cnt[1:0] == 2'h3);
    end
    spx_serial_port u_spx_serial_port (.clk_in(clk_in), .resetn_in(resetn_in), .avs_address_in(adr),
        .avs_read_in(rd), .avs_write_in(wr), .avs_writedata_in(wdat), .avs_byteenable_in(4'h1),
        .avs_readdata_out(rdat), .avs_waitrequest_out(wreq), .t1_ovf_in(t1_ovf), .t2_ovf_in(t2_ovf),
        .rxd_in(rxd_w), .rxd_out(rxd_d), .rxd_oe_out(rxd_oe), .txd_out(txd_d), .txd_oe_out(txd_oe));
    spx_partner u_spx_partner (.clk_in(clk_in), .txd_in(txd_w), .rxd_in(rxd_w), .rxd_out(p_rxd),
        .rxd_oe_out(p_oe));
    // Counts a comparison and reports a mismatch at once
    task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
        check_count++;
        if (seen !== exp) begin
            failures++;
            $display("[FAIL] %0t %s: seen %h expected %h", $time, what, seen, exp);
        end
    endtask
    task automatic give_verdict();
        $display("Counts: %0d checks, %0d failures", check_count, failures);
        if (failures == 0 && check_count > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    // Register access: request held until waitrequest is sampled low
    task automatic bus(input logic w, input logic [3:0] a, input logic [7:0] d, output logic [7:0] r);
        int n;
        @(posedge clk_in);
        adr <= a;
        wdat <= {24'h00_0000, d};
        wr <= w;
        rd <= !w;
        for (n = 0; n < 50; n++) begin
            @(posedge clk_in);
            if (wreq === 1'b0) break;
        end
        r = rdat[7:0];
        wr <= 1'b0;
        rd <= 1'b0;
        if (n >= 50) begin
            failures++;
            give_verdict();
        end
    endtask
    // Polls the control register until the given flag is set
    task automatic poll(input int b);
        int n;
        q = 8'h00;
        for (n = 0; n < 3000 && q[b] !== 1'b1; n++) bus(1'b0, `SPX_ADDR_CTL, 8'h00, q);
        if (n >= 3000) begin
            failures++;
            give_verdict();
        end
    endtask
    task automatic t_reset();
        check(txd_oe, 1'b0, "txd released at reset");
        bus(1'b0, `SPX_ADDR_CTL, 8'h00, q);
        check(q, `SPX_CTL_RST, "control reset value");
        bus(1'b0, `SPX_ADDR_BAUD, 8'h00, q);
        check(q, `SPX_BAUD_RST, "baud reset value");
        bus(1'b1, 4'hc, 8'hff, q);
        bus(1'b0, 4'hc, 8'h00, q);
        check(q, 8'h00, "unmapped read");
        $display("test reset done");
    endtask
    task automatic t_sync_tx(input logic rate, input logic [7:0] b, input logic [3:0] div);
        u_spx_partner.sync_begin(8'h00, 1'b0);
        bus(1'b1, `SPX_ADDR_CTL, {2'b00, rate, 5'h00}, q);
        bus(1'b1, `SPX_ADDR_BUF, b, q);
        poll(1);
        check(u_spx_partner.sync_rx, b, "sync transmit byte");
        check(u_spx_partner.rise_gap, div, "shift clock period");
        check(txd_oe, 1'b0, "txd released after frame");
        check(rxd_d, 1'b1, "data line left high");
        $display("test sync_tx done");
    endtask
    task automatic t_sync_rx();
        int n;
        u_spx_partner.sync_begin(8'h3c, 1'b1);
        bus(1'b1, `SPX_ADDR_CTL, 8'h10, q);
        poll(0);
        u_spx_partner.sync_begin(8'h00, 1'b0);
        bus(1'b0, `SPX_ADDR_BUF, 8'h00, q);
        check(q, 8'h3c, "sync receive byte");
        for (n = 0; n < 200; n++) begin
            @(posedge clk_in);
            if (txd_oe !== 1'b0) break;
        end
        check(n, 200, "no restart while done set");
        bus(1'b1, `SPX_ADDR_CTL, 8'h00, q);
        $display("test sync_rx done");
    endtask
    // Long frames: the tenth bit taken is the ninth data bit, so done must still be clear then
    task automatic t_async_tx(input logic [7:0] c, input logic [2:0] baud, input int bitclk, input logic [7:0] b);
        logic [9:0] f;
        int lag;
        bus(1'b1, `SPX_ADDR_CTL, c, q);
        bus(1'b1, `SPX_ADDR_BAUD, {5'h00, baud}, q);
        bus(1'b1, `SPX_ADDR_BUF, b, q);
        u_spx_partner.take(bitclk, f, lag);
        check(f, {c[7] ? c[3] : 1'b1, b, 1'b0}, "async frame and bit rate");
        check(lag <= bitclk + 8, 1'b1, "start within one rollover");
        bus(1'b0, `SPX_ADDR_CTL, 8'h00, q);
        check(q[1], !c[7], "transmit done only with stop bit");
        repeat (bitclk) @(posedge clk_in);
        bus(1'b0, `SPX_ADDR_CTL, 8'h00, q);
        check(q[1], 1'b1, "transmit done at stop bit");
        $display("test async_tx done");
    endtask
    task automatic t_async_rx();
        bus(1'b1, `SPX_ADDR_BAUD, 8'h01, q);
        bus(1'b1, `SPX_ADDR_CTL, 8'h40, q);
        u_spx_partner.send({1'b1, 8'h11, 1'b0}, 128, 99);
        bus(1'b0, `SPX_ADDR_CTL, 8'h00, q);
        check(q[0], 1'b0, "ignored while disabled");
        bus(1'b1, `SPX_ADDR_CTL, 8'h50, q);
        u_spx_partner.blip();
        u_spx_partner.send({1'b1, 8'hc3, 1'b0}, 128, 5);
        poll(0);
        bus(1'b0, `SPX_ADDR_BUF, 8'h00, q);
        check(q, 8'hc3, "false start dropped, glitch voted out");
        u_spx_partner.send({1'b1, 8'h77, 1'b0}, 128, 99);
        bus(1'b0, `SPX_ADDR_BUF, 8'h00, q);
        check(q, 8'hc3, "kept while done set");
        bus(1'b1, `SPX_ADDR_CTL, 8'h70, q);
        u_spx_partner.send({1'b0, 8'h55, 1'b0}, 128, 99);
        repeat (256) @(posedge clk_in);
        u_spx_partner.send({1'b1, 8'h0f, 1'b0}, 128, 99);
        poll(0);
        bus(1'b0, `SPX_ADDR_BUF, 8'h00, q);
        check(q, 8'h0f, "bad stop dropped, next taken");
        bus(1'b0, `SPX_ADDR_CTL, 8'h00, q);
        ctl = q;
        check(ctl.received_ninth_bit, 1'b1, "stop bit stored");
        check(q, 8'h75, "control after frame");
        $display("test async_rx done");
    endtask
    // Main sequence: reset, then the scenarios, then the verdict
    initial begin
        repeat (12) @(posedge clk_in);
        resetn_in <= 1'b1;
        repeat (3) @(posedge clk_in);
        t_reset();
        t_sync_tx(1'b0, 8'h96, `SPX_DIV_SLOW);
        t_sync_tx(1'b1, 8'h5a, `SPX_DIV_FAST);
        t_sync_rx();
        t_async_tx(8'h40, 3'h1, 128, 8'ha6);
        t_async_tx(8'h40, 3'h0, 256, 8'h01);
        t_async_tx(8'h40, 3'h2, 64, 8'h80);
        t_async_tx(8'h80, 3'h0, 64, 8'h3d);
        t_async_tx(8'hc8, 3'h2, 64, 8'hd4);
        t_async_rx();
        give_verdict();
    end
endmodule
